// [logic/ocrc_pkg.sv]
// Constants and carrier types for the overcurrent and retry configuration bank.
// Assumes a host that delivers whole 16-bit serial words as one-cycle strobes.
package ocrc_pkg;
	localparam int WORD_W        = 16;
	localparam int FIELD_W       = 9;
	localparam int BANK_BIT      = 13;
	localparam int ADDR_HI       = 12;
	localparam int ADDR_LO       = 10;
	localparam logic [2:0] ADDR_OCP   = 3'h4;
	localparam logic [2:0] ADDR_RETRY = 3'h5;
	localparam logic [8:0] OCP_RESET   = 9'h000;
	localparam logic [8:0] RETRY_RESET = 9'h000;
	localparam int RETRY_LIMIT   = 16;
	localparam int RETRY_CNT_W   = 5;
	localparam int DIV_LOW       = 256;
	localparam int DIV_HIGH      = 512;
	localparam int DIV_W         = 9;

	// Field positions inside the overcurrent profile word
	localparam int OCP_HIGH_RANGE_BIT  = 8;
	localparam int OCP_PRESCALE_BIT    = 7;
	localparam int OCP_INT_CLOCK_BIT   = 6;
	localparam int OCP_SENSE_RATIO_BIT = 5;
	localparam int OCP_FIRST_WIN_BIT   = 4;
	localparam int OCP_SECOND_WIN_BIT  = 3;
	localparam int OCP_UPPER_SEL_BIT   = 2;
	localparam int OCP_MIDDLE_SEL_BIT  = 1;
	localparam int OCP_LOWER_SEL_BIT   = 0;
	// Field positions inside the auto-retry word
	localparam int RTY_OFFSET_POL_BIT  = 8;
	localparam int RTY_PERIOD_HI_BIT   = 3;
	localparam int RTY_PERIOD_LO_BIT   = 2;
	localparam int RTY_UNLIMITED_BIT   = 1;
	localparam int RTY_CONTROL_BIT     = 0;

	typedef enum logic [1:0] {
		OCRC_LOWER_HIGHEST = 2'b00,
		OCRC_LOWER_MEDIUM  = 2'b01,
		OCRC_LOWER_LOWEST  = 2'b10
	} ocrc_lower_type;

	typedef enum logic [2:0] {
		OCRC_WIN_UPPER_ONE  = 3'b000,
		OCRC_WIN_UPPER_TWO  = 3'b001,
		OCRC_WIN_MIDDLE_ONE = 3'b010,
		OCRC_WIN_MIDDLE_TWO = 3'b011,
		OCRC_WIN_MOTOR_ONE  = 3'b100,
		OCRC_WIN_MOTOR_TWO  = 3'b101
	} ocrc_win_type;

	typedef enum logic [1:0] {
		OCRC_PH_UPPER  = 2'b00,
		OCRC_PH_MIDDLE = 2'b01,
		OCRC_PH_LOWER  = 2'b10
	} ocrc_phase_type;

	// Serial word as delivered by the serial front end
	typedef struct packed {
		logic [1:0] top;
		logic       bank;
		logic [2:0] addr;
		logic       spare;
		logic [8:0] field;
	} ocrc_word_type;

	// Per-channel decoded settings
	typedef struct packed {
		logic           upperLow;
		logic           middleLow;
		ocrc_lower_type lowerLevel;
		logic           lowRatio;
		logic           internalClock;
		logic           prescale512;
		ocrc_win_type   firstWindow;
		ocrc_win_type   secondWindow;
		logic           motorMode;
		logic           offsetAdd;
		logic [1:0]     retryPeriod;
		logic           retryUnlimited;
		logic           retryEnabled;
	} ocrc_chan_type;
endpackage : ocrc_pkg

// [logic/ocrc_bank.sv]
// Two-channel overcurrent profile and auto-retry configuration bank.
// Assumes whole serial words arrive as one-cycle strobes, synchronous to ref_clk.
//
// How it works
// RL1: HOCR zero forces highest lower level.
// RL2: HOCR one: lower bit picks medium/lowest.
// RL3: No current sensing during protection windows.
// RL4: External clock divided by 512 or 256.
// RL5: Clock bit one selects internal clock.
// RL6: Ratio bit one selects low-current ratio.
// RL7: Low ratio divides all thresholds by three.
// RL8: Bulb: upper, then middle, then lower.
// RL9: Motor: upper in single window, then lower.
// RL10: Bulb window bits pick each window length.
// RL11: Motor window bits pick one of four.
// RL12: Upper bit zero selects higher upper threshold.
// RL13: Middle bit picks middle threshold; motor ignores.
// RL14: Offset bit one adds, zero subtracts.
// RL15: Two bits select four retry periods.
// RL16: Unlimited bit allows endless retries when enabled.
// RL17: Limited mode stops after sixteen attempts.
// RL18: Counter survives delatch and fault removal.
// RL19: Bulb: retry bit one disables retry.
// RL20: Motor: retry bit one enables retry.
// RL21: Load type pin selects bulb or motor.
// RL22: Word bit thirteen selects channel bank.
// RL23: Bits 12..10 address register, 8..0 fields.
// RL24: Count retry attempts; flag when counter full.
`timescale 1ns/1ps
module ocrc_bank #(
	parameter int CHANNELS = 2
) (
	input  wire logic                              ref_clk,
	input  wire logic                              resetn,
	input  wire logic                              wordValid,
	input  wire ocrc_pkg::ocrc_word_type           wordIn,
	input  wire logic [CHANNELS-1:0]               load_type_pin,
	input  wire logic                              extClock,
	input  wire logic [CHANNELS-1:0]               intClockTick,
	input  wire logic [CHANNELS-1:0]               windowStart,
	input  wire logic [CHANNELS-1:0]               retryAttempt,
	input  wire logic [CHANNELS-1:0]               retryCounterReset,
	output ocrc_pkg::ocrc_chan_type [CHANNELS-1:0] chanCfg,
	output logic [CHANNELS-1:0][8:0]               ocpReadback,
	output logic [CHANNELS-1:0][8:0]               retryReadback,
	output ocrc_pkg::ocrc_phase_type [CHANNELS-1:0] thresholdPhase,
	output logic [CHANNELS-1:0]                    windowActive,
	output logic [CHANNELS-1:0]                    senseAllowed,
	output logic [CHANNELS-1:0]                    thresholdDivThree,
	output logic [CHANNELS-1:0]                    pwmTick,
	output logic [CHANNELS-1:0]                    retryAllowed,
	output logic [CHANNELS-1:0]                    counterFull,
	output logic [CHANNELS-1:0][ocrc_pkg::RETRY_CNT_W-1:0] retryCount
);
	import ocrc_pkg::*;

	// ----------------------------------------
	// Register write decode
	// ----------------------------------------
	logic [CHANNELS-1:0][8:0] ocpReg;
	logic [CHANNELS-1:0][8:0] retryReg;
	logic [CHANNELS-1:0]      ocpWrite;
	logic [CHANNELS-1:0]      retryWrite;
	logic                     extPrev;
	logic                     extEdge;

	// One strobe per channel and register; other addresses fall through
	always_comb begin
		ocpWrite   = '0;
		retryWrite = '0;
		for (int c = 0; c < CHANNELS; c++) begin
			if (wordValid && int'(wordIn.bank) == c) begin // RL22
				ocpWrite[c]   = (wordIn.addr == ADDR_OCP); // RL23
				retryWrite[c] = (wordIn.addr == ADDR_RETRY); // RL23
			end
		end
	end

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			ocpReg <= '{default: OCP_RESET};
		end else begin
			for (int c = 0; c < CHANNELS; c++) begin
				if (ocpWrite[c])
					ocpReg[c] <= wordIn.field; // RL23
			end
		end
	end

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			retryReg <= '{default: RETRY_RESET};
		end else begin
			for (int c = 0; c < CHANNELS; c++) begin
				if (retryWrite[c])
					retryReg[c] <= wordIn.field; // RL23
			end
		end
	end

	// ----------------------------------------
	// Register readback
	// ----------------------------------------
	assign ocpReadback   = ocpReg;
	assign retryReadback = retryReg;

	// ----------------------------------------
	// External clock edge detector
	// ----------------------------------------
	// Shared by both channel dividers
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn)
			extPrev <= 1'b0;
		else
			extPrev <= extClock;
	end
	assign extEdge = extClock && !extPrev;

	// ----------------------------------------
	// Per-channel decode, divider and retry counter
	// ----------------------------------------
	for (genvar c = 0; c < CHANNELS; c++) begin : gChan
		logic                   motor;
		logic [8:0]             ocp;
		logic [8:0]             rty;
		ocrc_chan_type          cfg;
		logic                   highRange;
		logic                   prescaleSel;
		logic                   intClockSel;
		logic                   senseRatioSel;
		logic                   firstWinSel;
		logic                   secondWinSel;
		logic                   upperSel;
		logic                   middleSel;
		logic                   lowerSel;
		logic                   offsetPol;
		logic [1:0]             periodSel;
		logic                   unlimitedSel;
		logic                   retryCtrl;
		ocrc_lower_type         lowerLevel;
		ocrc_win_type           firstWin;
		ocrc_win_type           secondWin;
		logic                   retryEnable;
		logic [DIV_W-1:0]       divCount;
		logic [DIV_W-1:0]       next_divCount;
		logic [DIV_W-1:0]       divLast;
		logic                   divHit;
		ocrc_phase_type         phase;
		ocrc_phase_type         next_phase;
		logic                   winStart;
		logic                   phaseStep;
		logic                   retryRestart;
		logic [RETRY_CNT_W-1:0] next_retryCount;

		// ----------------------------------------
		// Load type and field extraction
		// ----------------------------------------
		assign motor = load_type_pin[c]; // RL21
		assign ocp   = ocpReg[c];
		assign rty   = retryReg[c];

		assign highRange     = ocp[OCP_HIGH_RANGE_BIT];
		assign prescaleSel   = ocp[OCP_PRESCALE_BIT];
		assign intClockSel   = ocp[OCP_INT_CLOCK_BIT];
		assign senseRatioSel = ocp[OCP_SENSE_RATIO_BIT];
		assign firstWinSel   = ocp[OCP_FIRST_WIN_BIT];
		assign secondWinSel  = ocp[OCP_SECOND_WIN_BIT];
		assign upperSel      = ocp[OCP_UPPER_SEL_BIT];
		assign middleSel     = ocp[OCP_MIDDLE_SEL_BIT];
		assign lowerSel      = ocp[OCP_LOWER_SEL_BIT];
		assign offsetPol     = rty[RTY_OFFSET_POL_BIT];
		assign periodSel     = {rty[RTY_PERIOD_HI_BIT], rty[RTY_PERIOD_LO_BIT]};
		assign unlimitedSel  = rty[RTY_UNLIMITED_BIT];
		assign retryCtrl     = rty[RTY_CONTROL_BIT];

		// ----------------------------------------
		// Lower threshold level
		// ----------------------------------------
		// Low range bit pins the highest level; select bit ignored
		always_comb begin
			unique case ({highRange, lowerSel})
				2'b00: lowerLevel = OCRC_LOWER_HIGHEST; // RL1
				2'b01: lowerLevel = OCRC_LOWER_HIGHEST; // RL1
				2'b10: lowerLevel = OCRC_LOWER_MEDIUM; // RL2
				2'b11: lowerLevel = OCRC_LOWER_LOWEST; // RL2
			endcase
		end

		// ----------------------------------------
		// Window durations
		// ----------------------------------------
		// Motor has one window; second window code is a fixed filler
		always_comb begin
			if (motor) begin
				unique case ({firstWinSel, secondWinSel}) // RL11
					2'b00: firstWin = OCRC_WIN_MOTOR_ONE;
					2'b01: firstWin = OCRC_WIN_MOTOR_TWO;
					2'b10: firstWin = OCRC_WIN_UPPER_ONE;
					2'b11: firstWin = OCRC_WIN_UPPER_TWO;
				endcase
				secondWin = OCRC_WIN_MIDDLE_ONE;
			end else begin
				firstWin  = firstWinSel ? OCRC_WIN_UPPER_TWO : OCRC_WIN_UPPER_ONE; // RL10
				secondWin = secondWinSel ? OCRC_WIN_MIDDLE_TWO : OCRC_WIN_MIDDLE_ONE; // RL10
			end
		end

		// ----------------------------------------
		// Retry enable polarity
		// ----------------------------------------
		assign retryEnable = motor ? retryCtrl : !retryCtrl; // RL19 RL20

		// ----------------------------------------
		// Decoded configuration
		// ----------------------------------------
		always_comb begin
			cfg                = '0;
			cfg.motorMode      = motor;
			cfg.upperLow       = upperSel; // RL12
			cfg.middleLow      = motor ? 1'b0 : middleSel; // RL13
			cfg.lowerLevel     = lowerLevel;
			cfg.prescale512    = prescaleSel;
			cfg.internalClock  = intClockSel; // RL5
			cfg.lowRatio       = senseRatioSel; // RL6
			cfg.firstWindow    = firstWin;
			cfg.secondWindow   = secondWin;
			cfg.offsetAdd      = offsetPol; // RL14
			cfg.retryPeriod    = periodSel; // RL15
			cfg.retryUnlimited = unlimitedSel;
			cfg.retryEnabled   = retryEnable;
		end

		assign chanCfg[c]           = cfg;
		assign thresholdDivThree[c] = cfg.lowRatio; // RL7

		// ----------------------------------------
		// PWM clock divider
		// ----------------------------------------
		assign divLast = cfg.prescale512 ? DIV_W'(DIV_HIGH - 1) : DIV_W'(DIV_LOW - 1); // RL4
		assign divHit  = (divCount >= divLast);

		// Counter parks at zero in internal mode so a switch back starts clean
		always_comb begin
			next_divCount = divCount;
			if (cfg.internalClock)
				next_divCount = '0;
			else if (extEdge)
				next_divCount = divHit ? '0 : divCount + 1'b1; // RL4
		end

		always_ff @(posedge ref_clk or negedge resetn) begin
			if (!resetn)
				divCount <= '0;
			else
				divCount <= next_divCount;
		end

		// Internal mode passes the tick through one flop
		always_ff @(posedge ref_clk or negedge resetn) begin
			if (!resetn)
				pwmTick[c] <= 1'b0;
			else if (cfg.internalClock)
				pwmTick[c] <= intClockTick[c]; // RL5
			else if (extEdge)
				pwmTick[c] <= divHit; // RL4
			else
				pwmTick[c] <= 1'b0;
		end

		// ----------------------------------------
		// Threshold phase sequencing
		// ----------------------------------------
		// Window start opens the upper phase; internal ticks step it on
		assign winStart     = windowStart[c];
		assign phaseStep    = windowActive[c] && intClockTick[c];
		assign retryRestart = retryAttempt[c] && (phase == OCRC_PH_LOWER);

		always_comb begin
			next_phase = phase;
			if (winStart) begin
				next_phase = OCRC_PH_UPPER;
			end else if (phaseStep) begin
				unique case (phase)
					OCRC_PH_UPPER:  next_phase = motor ? OCRC_PH_LOWER : OCRC_PH_MIDDLE; // RL8 RL9
					OCRC_PH_MIDDLE: next_phase = OCRC_PH_LOWER; // RL8
					OCRC_PH_LOWER:  next_phase = OCRC_PH_LOWER;
					default:        next_phase = OCRC_PH_LOWER;
				endcase
			end else if (retryRestart) begin
				next_phase = OCRC_PH_UPPER;
			end
		end

		always_ff @(posedge ref_clk or negedge resetn) begin
			if (!resetn)
				phase <= OCRC_PH_LOWER;
			else
				phase <= next_phase;
		end

		// ----------------------------------------
		// Window and sense gating
		// ----------------------------------------
		assign thresholdPhase[c] = phase;
		assign windowActive[c]   = (phase != OCRC_PH_LOWER);
		assign senseAllowed[c]   = !windowActive[c]; // RL3

		// ----------------------------------------
		// Retry attempt counter
		// ----------------------------------------
		// Only its own reset pulse clears it; an allowed attempt in that cycle wins.
		// Saturates at the limit so unlimited mode cannot wrap below full.
		always_comb begin
			next_retryCount = retryCount[c];
			if (retryAttempt[c] && retryAllowed[c]) begin
				if (!counterFull[c])
					next_retryCount = retryCount[c] + 1'b1; // RL24
			end else if (retryCounterReset[c]) begin
				next_retryCount = '0; // RL18
			end
		end

		always_ff @(posedge ref_clk or negedge resetn) begin
			if (!resetn)
				retryCount[c] <= '0;
			else
				retryCount[c] <= next_retryCount;
		end

		// ----------------------------------------
		// Retry permission
		// ----------------------------------------
		assign counterFull[c] = (retryCount[c] == RETRY_CNT_W'(RETRY_LIMIT)); // RL24

		always_comb begin
			if (!cfg.retryEnabled)
				retryAllowed[c] = 1'b0;
			else if (cfg.retryUnlimited)
				retryAllowed[c] = 1'b1; // RL16
			else
				retryAllowed[c] = !counterFull[c]; // RL17
		end
	end
endmodule : ocrc_bank

// [testbench/ocrc_bank_properties.sv]
// Port assertions for the configuration bank.
// Bound to every ocrc_bank instance.
`timescale 1ns/1ps
module ocrc_bank_properties #(
	parameter int CHANNELS = 2
) (
	input wire logic                                    ref_clk,
	input wire logic                                    resetn,
	input wire logic                                    wordValid,
	input wire ocrc_pkg::ocrc_word_type                 wordIn,
	input wire logic [CHANNELS-1:0]                     load_type_pin,
	input wire ocrc_pkg::ocrc_chan_type [CHANNELS-1:0]  chanCfg,
	input wire logic [CHANNELS-1:0][8:0]                ocpReadback,
	input wire logic [CHANNELS-1:0][8:0]                retryReadback,
	input wire logic [CHANNELS-1:0]                     windowActive,
	input wire logic [CHANNELS-1:0]                     senseAllowed,
	input wire logic [CHANNELS-1:0]                     retryAllowed,
	input wire logic [CHANNELS-1:0][4:0]                retryCount
);
	import ocrc_pkg::*;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!resetn);
	property p_wr0; wordValid && !wordIn.bank && wordIn.addr == ADDR_OCP |=> ocpReadback[0] == $past(wordIn.field); endproperty
	a_wr0: assert property (p_wr0) else $error("ocp write lost");
	property p_wr1; wordValid && wordIn.bank && wordIn.addr == ADDR_RETRY |=> retryReadback[1] == $past(wordIn.field); endproperty
	a_wr1: assert property (p_wr1) else $error("bank write lost");
	property p_hold; !wordValid |=> $stable(ocpReadback) && $stable(retryReadback); endproperty
	a_hold: assert property (p_hold) else $error("register changed");
	property p_sns; senseAllowed == ~windowActive; endproperty
	a_sns: assert property (p_sns) else $error("sense in window");
	property p_low; chanCfg[0].lowerLevel == (ocpReadback[0][8] ? {ocpReadback[0][0], ~ocpReadback[0][0]} : 2'b00); endproperty
	a_low: assert property (p_low) else $error("lower level");
	property p_clk; {chanCfg[0].prescale512, chanCfg[0].internalClock, chanCfg[0].lowRatio} == ocpReadback[0][7:5]; endproperty
	a_clk: assert property (p_clk) else $error("clock or ratio");
	property p_ret; chanCfg[0].retryEnabled == (retryReadback[0][0] ^ !load_type_pin[0]); endproperty
	a_ret: assert property (p_ret) else $error("retry enable");
	property p_lim; !retryReadback[0][1] && retryCount[0] >= 5'd16 |-> !retryAllowed[0]; endproperty
	a_lim: assert property (p_lim) else $error("retry past limit");
endmodule : ocrc_bank_properties

bind ocrc_bank ocrc_bank_properties #(.CHANNELS(CHANNELS)) i_chk (.ref_clk, .resetn, .wordValid, .wordIn,
	.load_type_pin, .chanCfg, .ocpReadback, .retryReadback, .windowActive, .senseAllowed, .retryAllowed, .retryCount);

// [testbench/ocrc_host.sv]
// Host model sending whole serial words.
// Assumes the bank takes a word on a rising edge with wordValid high.
`timescale 1ns/1ps
module ocrc_host (
	input wire logic               ref_clk,
	output logic                   wordValid,
	output ocrc_pkg::ocrc_word_type wordIn
);
	import ocrc_pkg::*;
	initial begin
		wordValid = 1'b0;
		wordIn = '1;
	end
	task send(input logic bank, input logic [2:0] addr, input logic [8:0] field);
		@(posedge ref_clk);
		wordValid <= 1'b1;
		wordIn <= {2'h0, bank, addr, 1'b0, field};
		@(posedge ref_clk);
		wordValid <= 1'b0;
		wordIn <= ~wordIn;
	endtask : send
endmodule : ocrc_host

// [testbench/tb.sv]
// Bench for the configuration bank.
// Uses the host model for serial words.
`timescale 1ns/1ps
module tb;
	import ocrc_pkg::*;
	logic                 ref_clk = 0;
	logic                 resetn = 0;
	logic                 wordValid;
	ocrc_word_type        wordIn;
	logic [1:0]           load_type_pin = 2'b10;
	logic [1:0]           tick = 0;
	logic [1:0]           start = 0;
	logic [1:0]           att = 0;
	logic [1:0]           clr = 0;
	logic                 ext = 0;
	logic [1:0]           pwm;
	ocrc_chan_type [1:0]  cfg;
	logic [1:0][8:0]      ocp;
	logic [1:0][8:0]      rty;
	ocrc_phase_type [1:0] ph;
	logic [1:0]           win;
	logic [1:0]           sns;
	logic [1:0]           div3;
	logic [1:0]           allow;
	logic [1:0]           full;
	logic [1:0][4:0]      cnt;
	int                   fails = 0;
	int                   n_checks = 0;
	always #5 ref_clk = ~ref_clk;
	ocrc_host host (.ref_clk, .wordValid, .wordIn);
	ocrc_bank i_ocrc_bank (.ref_clk, .resetn, .wordValid, .wordIn, .load_type_pin, .extClock(ext),
		.intClockTick(tick), .windowStart(start), .retryAttempt(att), .retryCounterReset(clr),
		.chanCfg(cfg), .ocpReadback(ocp), .retryReadback(rty), .thresholdPhase(ph), .windowActive(win),
		.senseAllowed(sns), .thresholdDivThree(div3), .pwmTick(pwm), .retryAllowed(allow),
		.counterFull(full), .retryCount(cnt));
	task chk(input string what, input logic [17:0] got, input logic [17:0] exp);
		n_checks++;
		if (got !== exp) begin
			fails++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	task pulse(input int k, input logic [1:0] v);
		@(posedge ref_clk);
		case (k)
			0: start <= v;
			1: tick <= v;
			2: att <= v;
			default: clr <= v;
		endcase
		@(posedge ref_clk);
		{start, tick, att, clr} <= '0;
		#1;
	endtask : pulse
	task t_win;
		pulse(0, 2'b11);
		chk("upper", {sns, ph}, {2'b00, OCRC_PH_UPPER, OCRC_PH_UPPER});
		pulse(1, 2'b11);
		chk("second", ph, {OCRC_PH_LOWER, OCRC_PH_MIDDLE});
		pulse(1, 2'b11);
		chk("lower", {sns, ph}, {2'b11, OCRC_PH_LOWER, OCRC_PH_LOWER});
	endtask : t_win
	task t_regs;
		host.send(1'b0, ADDR_OCP, 9'h1a5);
		host.send(1'b1, ADDR_RETRY, 9'h10b);
		host.send(1'b0, 3'h3, 9'h0ff);
		#1;
		chk("regs", {ocp[0], rty[1]}, {9'h1a5, 9'h10b});
		chk("others", {ocp[1], rty[0]}, 18'h0);
		chk("ocp0", {div3, cfg[0].lowerLevel, cfg[0].prescale512, cfg[0].upperLow}, 6'h1b);
		chk("rty1", {cfg[1].offsetAdd, cfg[1].retryPeriod, cfg[1].retryUnlimited, cfg[1].retryEnabled,
			cfg[0].retryEnabled}, 6'b110111);
		for (int k = 0; k < 4; k++) begin
			host.send(1'b1, ADDR_OCP, {4'h0, k[1:0], 3'h0});
			host.send(1'b0, ADDR_OCP, {k[1], 1'b0, k[0], 1'b0, k[1], k[0], 2'b00, k[0]});
			#1;
			chk("win", {cfg[1].firstWindow, cfg[0].firstWindow, cfg[0].secondWindow, cfg[0].lowerLevel,
				cfg[0].internalClock}, {~k[1], 1'b0, k[0], 2'b00, k[1], 2'b01, k[0],
				k[1] ? {k[0], ~k[0]} : 2'b00, k[0]});
		end
	endtask : t_regs
	task ext_edges(input int e, output int n);
		n = 0;
		repeat (e) begin
			@(posedge ref_clk);
			ext <= 1'b1;
			#1 n += pwm[1];
			@(posedge ref_clk);
			ext <= 1'b0;
			#1 n += pwm[1];
		end
		@(posedge ref_clk);
		#1 n += pwm[1];
	endtask : ext_edges
	task t_pwm;
		int n;
		host.send(1'b1, ADDR_OCP, 9'h000);
		ext_edges(DIV_LOW, n);
		chk("div low", 18'(n), 18'd1);
		host.send(1'b1, ADDR_OCP, 9'h080);
		ext_edges(DIV_LOW, n);
		chk("div high half", 18'(n), 18'd0);
		ext_edges(DIV_LOW, n);
		chk("div high", 18'(n), 18'd1);
		host.send(1'b1, ADDR_OCP, 9'h040);
		pulse(1, 2'b10);
		chk("int tick", pwm, 2'b10);
	endtask : t_pwm
	task t_retry;
		repeat (17) pulse(2, 2'b01);
		chk("limit", {cnt[0], full[0], allow[0]}, {5'd16, 2'b10});
		host.send(1'b0, ADDR_RETRY, 9'h002);
		#1;
		chk("unlimited", allow[0], 1'b1);
		host.send(1'b0, ADDR_RETRY, 9'h003);
		#1;
		chk("disabled", allow[0], 1'b0);
		pulse(3, 2'b01);
		chk("cleared", {cnt[0], full[0]}, 6'h0);
	endtask : t_retry
	task end_sim;
		$display("checks %0d mismatches %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : end_sim
	initial begin
		repeat (12) @(posedge ref_clk);
		resetn <= 1'b1;
		@(posedge ref_clk);
		#1;
		chk("reset ocp", ocp, 18'h0);
		chk("reset rty", rty, 18'h0);
		t_win();
		t_regs();
		t_pwm();
		t_retry();
		end_sim();
	end
	initial begin
		#100000;
		fails++;
		end_sim();
	end
endmodule : tb
